// [logic/mem_phy_datapath.sv]
/*
 * double-data-rate memory datapath: write launch, read capture and memory
 * clock generation for sdram, reduced-latency dram and quad-rate sram.
 * assumes the pad cells outside mux each rise/fall pair onto the pin, that
 * data pairs are launched by the -90 degree clock and strobes by the
 * 0 degree clock, and that incoming read pairs were split at the pad.
 */
`timescale 1ns/10ps
`include "mem_phy_cfg.svh"

// Operation
// - read strobe delayed to mid data window
// - strobe from 0 deg, data from -90 deg
// - ddr bursts of four; first-generation also two
// - write clocks free-running, never released
// - data both edges, command rising only
// - common-io bidirectional, separate-io split ports
// - one active-high write mask line
// - read clock pins never driven, capture shifted
// - read valid input gates capture like data
// - read edge-aligned in, write centred out
// - sram moves two or four words
// - b2 write address on falling edge
// - sram control sampled on rising edge
// - single-clock or multi-device clocking for sram
// - complement clocks exact, adjacent ddr registers
// - sram separate read and write ports
// - memory clocks via ddr output registers
module mem_phy_datapath (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // configuration from core logic
    input wire mem_phy_pkg::mem_kind_t mem_kind,
    input wire logic ddr1_burst2,
    input wire logic multi_sram,
    // user command side
    input wire logic cmd_valid,
    input wire mem_phy_pkg::cmd_t cmd,
    output logic cmd_ready,
    // user read side
    output logic rd_valid,
    output mem_phy_pkg::pair_t rd_word,
    // command and address pins
    output logic [`PHY_ADDR_W-1:0] addr_rise,
    output logic [`PHY_ADDR_W-1:0] addr_fall,
    output logic mem_select_n,
    output logic mem_write_n,
    // bidirectional data pins
    output mem_phy_pkg::pair_t dq_out,
    output logic dq_oe,
    input wire mem_phy_pkg::pair_t dq_in,
    // separate write data pins
    output mem_phy_pkg::pair_t d_out,
    // strobe pins
    output logic [1:0] strobe_out,
    output logic strobe_oe,
    output logic complement_strobe_oe,
    input wire logic strobe_in,
    input wire logic read_valid_input,
    // mask
    output logic [1:0] write_mask_line,
    // memory clocks: rise/fall halves, true then complement
    output logic [1:0] memory_input_clock,
    output logic [1:0] memory_input_clock_n,
    output logic [1:0] write_clock_to_memory,
    output logic [1:0] write_clock_to_memory_n,
    output logic [1:0] sram_out_clock,
    output logic [1:0] sram_out_clock_n
);

    // ========================================
    // decode
    function automatic logic is_sram(input mem_phy_pkg::mem_kind_t k);
        is_sram = (k == mem_phy_pkg::kind_sram_b2) ||
                  (k == mem_phy_pkg::kind_sram_b4);
    endfunction : is_sram

    function automatic logic is_rl(input mem_phy_pkg::mem_kind_t k);
        is_rl = (k == mem_phy_pkg::kind_rl_common_io) ||
                (k == mem_phy_pkg::kind_rl_separate_io);
    endfunction : is_rl

    function automatic logic is_shared_dq(input mem_phy_pkg::mem_kind_t k);
        is_shared_dq = !is_sram(k) &&
                       (k != mem_phy_pkg::kind_rl_separate_io);
    endfunction : is_shared_dq

    logic short_burst;
    logic [1:0] beats;

    always_comb begin
        short_burst = (mem_kind == mem_phy_pkg::kind_sram_b2) ||
                      ((mem_kind == mem_phy_pkg::kind_ddr1) &&
                       ddr1_burst2);
        beats = short_burst ? `PHY_BEATS_SHORT : `PHY_BEATS_LONG;
    end

    // ========================================
    // memory clocks
    // true and complement come from neighbouring cells fed inverted halves,
    // so the pair cannot drift apart in logic.
    logic [3:0] clk_run;
    logic [1:0] clk_true [4];
    logic [1:0] clk_comp [4];

    always_comb begin
        clk_run[0] = 1'b1;
        clk_run[1] = is_rl(mem_kind);
        clk_run[2] = is_sram(mem_kind);
        clk_run[3] = is_sram(mem_kind) && multi_sram;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_clk
            ddr_out_reg #(.W(1)) u_true (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .d_rise(clk_run[g]),
                .d_fall(1'b0),
                .q_rise(clk_true[g][1]),
                .q_fall(clk_true[g][0])
            );
            ddr_out_reg #(.W(1)) u_comp (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .d_rise(~clk_run[g]),
                .d_fall(1'b1),
                .q_rise(clk_comp[g][1]),
                .q_fall(clk_comp[g][0])
            );
        end
    endgenerate

    // input clock pair doubles as k for sram; write clock pair is dk
    always_comb begin
        memory_input_clock = is_sram(mem_kind) ? clk_true[2] : clk_true[0];
        memory_input_clock_n = is_sram(mem_kind) ? clk_comp[2] :
                               clk_comp[0];
        write_clock_to_memory = clk_true[1];
        write_clock_to_memory_n = clk_comp[1];
        sram_out_clock = clk_true[3];
        sram_out_clock_n = clk_comp[3];
    end

    // ========================================
    // command sequencer
    mem_phy_pkg::phase_t phase_r, phase_nxt;
    logic [1:0] beat_r, beat_nxt;
    mem_phy_pkg::cmd_t cmd_r, cmd_nxt;
    logic ready_r, ready_nxt;

    always_comb begin
        phase_nxt = phase_r;
        beat_nxt = beat_r;
        cmd_nxt = cmd_r;
        ready_nxt = ready_r;
        unique case (phase_r)
            mem_phy_pkg::st_idle: begin
                if (cmd_valid && ready_r) begin
                    cmd_nxt = cmd;
                    beat_nxt = `PHY_BEAT_ZERO;
                    ready_nxt = 1'b0;
                    phase_nxt = cmd.write ? mem_phy_pkg::st_write :
                                mem_phy_pkg::st_read;
                end
            end
            mem_phy_pkg::st_write, mem_phy_pkg::st_read: begin
                beat_nxt = beat_r + 2'h1;
                if (beat_r + 2'h1 == beats) begin
                    phase_nxt = mem_phy_pkg::st_idle;
                    ready_nxt = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= mem_phy_pkg::st_idle;
            beat_r <= `PHY_BEAT_ZERO;
            cmd_r <= '0;
            ready_r <= `PHY_RST_BIT_HI;
        end else begin
            phase_r <= phase_nxt;
            beat_r <= beat_nxt;
            cmd_r <= cmd_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ========================================
    // pin launch
    logic first_beat;
    logic wr_go;
    mem_phy_pkg::pair_t wr_pair;
    logic [1:0] wr_mask;
    logic [`PHY_ADDR_W-1:0] a_rise_nxt, a_fall_nxt;
    logic sel_n_nxt, we_n_nxt;
    mem_phy_pkg::pair_t dq_nxt, d_nxt;
    logic dq_oe_nxt, st_oe_nxt;
    logic [1:0] st_nxt, mask_nxt;

    always_comb begin
        first_beat = (phase_r != mem_phy_pkg::st_idle) &&
                     (beat_r == `PHY_BEAT_ZERO);
        wr_go = (phase_r == mem_phy_pkg::st_write);
        // beat 0 carries words 0/1, beat 1 words 2/3
        wr_pair.rise = beat_r[0] ? cmd_r.wdata[23:16] : cmd_r.wdata[7:0];
        wr_pair.fall = beat_r[0] ? cmd_r.wdata[31:24] : cmd_r.wdata[15:8];
        wr_mask = beat_r[0] ? cmd_r.wmask[3:2] : cmd_r.wmask[1:0];
        // command and address change for the rising edge, except the b2 sram write address on the falling half
        a_rise_nxt = addr_rise;
        a_fall_nxt = addr_fall;
        sel_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        if (first_beat) begin
            sel_n_nxt = 1'b0;
            we_n_nxt = !wr_go;
            if (wr_go && mem_kind == mem_phy_pkg::kind_sram_b2) begin
                a_fall_nxt = cmd_r.addr;
            end else begin
                a_rise_nxt = cmd_r.addr;
            end
        end
        dq_nxt = '0;
        d_nxt = '0;
        dq_oe_nxt = 1'b0;
        if (wr_go && is_shared_dq(mem_kind)) begin
            dq_nxt = wr_pair;
            dq_oe_nxt = 1'b1;
        end else if (wr_go) begin
            d_nxt = wr_pair;
        end
        // sdram strobe follows the 0 degree clock, only while writing
        st_oe_nxt = wr_go && !is_sram(mem_kind) && !is_rl(mem_kind);
        st_nxt = st_oe_nxt ? 2'b10 : 2'b00;
        mask_nxt = (wr_go && !is_sram(mem_kind)) ? wr_mask : 2'b00;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_rise <= `PHY_RST_ADDR;
            addr_fall <= `PHY_RST_ADDR;
            mem_select_n <= `PHY_RST_BIT_HI;
            mem_write_n <= `PHY_RST_BIT_HI;
            dq_out <= '0;
            d_out <= '0;
            dq_oe <= `PHY_RST_BIT;
            strobe_oe <= `PHY_RST_BIT;
            strobe_out <= 2'h0;
            write_mask_line <= 2'h0;
            complement_strobe_oe <= `PHY_RST_BIT;
        end else begin
            addr_rise <= a_rise_nxt;
            addr_fall <= a_fall_nxt;
            mem_select_n <= sel_n_nxt;
            mem_write_n <= we_n_nxt;
            dq_out <= dq_nxt;
            d_out <= d_nxt;
            dq_oe <= dq_oe_nxt;
            strobe_oe <= st_oe_nxt;
            strobe_out <= st_nxt;
            write_mask_line <= mask_nxt;
            complement_strobe_oe <= 1'b0;
        end
    end

    // ========================================
    // read capture
    // inputs cross from the pads through two flops; the third strobe stage
    // is the shifted copy, landing half a window after the raw edge.
    logic [3:0] strb_sync_r, strb_sync_nxt;
    logic [1:0] vld_sync_r, vld_sync_nxt;
    mem_phy_pkg::pair_t dq_s1_r, dq_s2_r;
    logic cap_edge;
    logic rd_ok;
    logic rd_valid_nxt;
    mem_phy_pkg::pair_t rd_word_nxt;

    always_comb begin
        strb_sync_nxt = {strb_sync_r[2:0], strobe_in};
        vld_sync_nxt = {vld_sync_r[0], read_valid_input};
        cap_edge = strb_sync_r[2] && !strb_sync_r[3];
        // valid is treated like data and must be present on rl reads
        rd_ok = !is_rl(mem_kind) || vld_sync_r[1];
        rd_valid_nxt = cap_edge && rd_ok;
        rd_word_nxt = rd_word;
        if (cap_edge && rd_ok) begin
            // sram reads come on dq pins, separate from d_out
            rd_word_nxt = dq_s2_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strb_sync_r <= 4'h0;
            vld_sync_r <= 2'h0;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            rd_valid <= `PHY_RST_BIT;
            rd_word <= '0;
        end else begin
            strb_sync_r <= strb_sync_nxt;
            vld_sync_r <= vld_sync_nxt;
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
            rd_valid <= rd_valid_nxt;
            rd_word <= rd_word_nxt;
        end
    end

    always_comb begin
        cmd_ready = ready_r;
    end

endmodule : mem_phy_datapath

// [common/mem_phy_cfg.svh]
/*
 * constants for the external memory datapath: widths, burst counts and
 * reset values.
 * assumes inclusion by bare name from design and testbench files.
 */
`ifndef MEM_PHY_CFG_SVH
`define MEM_PHY_CFG_SVH

`define PHY_WORD_W 8
`define PHY_ADDR_W 16
`define PHY_BURST_W 32
`define PHY_MASK_W 4
`define PHY_BEATS_SHORT 2'h1
`define PHY_BEATS_LONG 2'h2
`define PHY_BEAT_ZERO 2'h0
`define PHY_RST_BYTE 8'h00
`define PHY_RST_ADDR 16'h0000
`define PHY_RST_BIT 1'b0
`define PHY_RST_BIT_HI 1'b1

`endif

// [common/mem_phy_pkg.sv]
/*
 * types shared by the memory datapath modules.
 * assumes mem_phy_cfg.svh is on the include path.
 */
`include "mem_phy_cfg.svh"

package mem_phy_pkg;

    // ========================================
    // memory families
    typedef enum logic [2:0] {
        kind_ddr1 = 3'h0,
        kind_ddr2 = 3'h1,
        kind_rl_common_io = 3'h2,
        kind_rl_separate_io = 3'h3,
        kind_sram_b2 = 3'h4,
        kind_sram_b4 = 3'h5
    } mem_kind_t;

    // ========================================
    // carriers
    typedef struct packed {
        logic write;
        logic [`PHY_ADDR_W-1:0] addr;
        logic [`PHY_BURST_W-1:0] wdata;
        logic [`PHY_MASK_W-1:0] wmask;
    } cmd_t;

    typedef struct packed {
        logic [`PHY_WORD_W-1:0] rise;
        logic [`PHY_WORD_W-1:0] fall;
    } pair_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_write = 3'b010,
        st_read = 3'b100
    } phase_t;

endpackage : mem_phy_pkg

// [logic/ddr_out_reg.sv]
/*
 * one double-data-rate output register: the half launched on the rising
 * edge and the half launched on the falling edge, held in flops.
 * assumes the pad multiplexer that picks the half per edge sits outside.
 */
`timescale 1ns/10ps

module ddr_out_reg #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // halves in
    input wire logic [W-1:0] d_rise,
    input wire logic [W-1:0] d_fall,
    // halves out
    output logic [W-1:0] q_rise,
    output logic [W-1:0] q_fall
);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_rise <= '0;
            q_fall <= '0;
        end else begin
            q_rise <= d_rise;
            q_fall <= d_fall;
        end
    end

endmodule : ddr_out_reg

// [testbench/mem_phy_assertions.sv]
/* concurrent checks on the memory datapath ports.
   assumes binding onto mem_phy_datapath, one clock domain. */
`timescale 1ns/10ps
`include "mem_phy_cfg.svh"
module mem_phy_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // watched ports
    input wire mem_phy_pkg::mem_kind_t mem_kind,
    input wire logic cmd_valid,
    input wire mem_phy_pkg::cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic rd_valid,
    input wire logic mem_select_n,
    input wire logic [`PHY_ADDR_W-1:0] addr_fall,
    input wire logic dq_oe,
    input wire logic [1:0] strobe_out,
    input wire logic complement_strobe_oe,
    input wire logic strobe_in,
    input wire logic read_valid_input,
    input wire logic [1:0] memory_input_clock,
    input wire logic [1:0] memory_input_clock_n,
    input wire logic [1:0] write_clock_to_memory
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire take = cmd_valid && cmd_ready;
    logic [`PHY_ADDR_W-1:0] taken_addr_r, taken_addr_nxt;
    // ========================================
    // address of the last taken command
    always_comb taken_addr_nxt = take ? cmd.addr : taken_addr_r;
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b) taken_addr_r <= '0;
        else taken_addr_r <= taken_addr_nxt;
    // ========================================
    // sequences
    sequence beat_s;
        dq_oe && strobe_out == 2'h2;
    endsequence
    sequence ddr_burst_s;
        beat_s ##1 beat_s ##1 !dq_oe;
    endsequence
    sequence read_edge_s;
        $rose(strobe_in) && read_valid_input &&
            mem_kind <= mem_phy_pkg::kind_rl_common_io;
    endsequence
    // ========================================
    // checks
    busy_after_take_a: assert property (
        take |=> !cmd_ready ##[1:3] cmd_ready)
        else $error("ready did not drop and return");
    select_delay_a: assert property (take |-> ##[2:3] !mem_select_n)
        else $error("select missing after take");
    select_pulse_a: assert property (!mem_select_n |=> mem_select_n)
        else $error("select longer than one cycle");
    ddr_write_a: assert property (take && cmd.write &&
        mem_kind == mem_phy_pkg::kind_ddr2 |-> ##[2:3] ddr_burst_s)
        else $error("ddr write burst wrong");
    fall_addr_a: assert property (take && cmd.write &&
        mem_kind == mem_phy_pkg::kind_sram_b2 |->
        ##[2:3] (!mem_select_n && addr_fall == taken_addr_r))
        else $error("write address not on falling half");
    strobe_oe_off_a: assert property (!complement_strobe_oe)
        else $error("read clock pin driven");
    clock_pair_a: assert property ($past(rst_b) |->
        memory_input_clock_n == ~memory_input_clock)
        else $error("clock pair not complementary");
    write_clock_run_a: assert property ($past(rst_b) &&
        mem_kind == mem_phy_pkg::kind_rl_common_io && $stable(mem_kind)
        |-> write_clock_to_memory == 2'h2)
        else $error("write clock stopped");
    read_latency_a: assert property (
        read_edge_s |-> ##[3:5] rd_valid)
        else $error("read pair not delivered");
    read_pulse_a: assert property (rd_valid |=> !rd_valid)
        else $error("read valid longer than one cycle");
    valid_gate_a: assert property (
        $rose(strobe_in) && !read_valid_input &&
        mem_kind == mem_phy_pkg::kind_rl_common_io |-> !rd_valid[*6])
        else $error("capture without read valid");
endmodule : mem_phy_assertions

bind mem_phy_datapath mem_phy_assertions chk_u (.sys_clk, .rst_b, .mem_kind,
    .cmd_valid, .cmd, .cmd_ready, .rd_valid, .mem_select_n, .addr_fall,
    .dq_oe, .strobe_out, .complement_strobe_oe, .strobe_in,
    .read_valid_input, .memory_input_clock, .memory_input_clock_n,
    .write_clock_to_memory);

// [testbench/mem_chip_model.sv]
/* behavioural memory chip: answers each read command with one pair.
   assumes command pins of mem_phy_datapath, strobe idle low. */
`timescale 1ns/10ps
module mem_chip_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // command pins
    input wire logic mem_select_n,
    input wire logic mem_write_n,
    input wire logic [15:0] addr_rise,
    // knobs from the bench
    input wire logic slow,
    input wire logic drop_valid,
    // read pins
    output mem_phy_pkg::pair_t dq_in,
    output logic strobe_in,
    output logic read_valid_input
);
    logic [7:0] a;
    initial begin
        dq_in = '0;
        strobe_in = 1'b0;
        read_valid_input = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (rst_b && !mem_select_n && mem_write_n) begin
                // a read never waits behind a write
                a = addr_rise[7:0];
                repeat (slow ? 3 : 1) @(negedge sys_clk);
                // data moves with the strobe edge, held past capture
                dq_in = '{rise: a, fall: ~a};
                read_valid_input = !drop_valid;
                strobe_in = 1'b1;
                @(negedge sys_clk);
                strobe_in = 1'b0;
                repeat (2) @(negedge sys_clk);
                read_valid_input = 1'b0;
                // released bus: never leave the old value standing
                dq_in = ~dq_in;
            end
        end
    end
endmodule : mem_chip_model

// [testbench/tb_mem_phy_datapath.sv]
/* self-checking bench for mem_phy_datapath with a chip model.
   assumes a 50 MHz clock and the package compiled first. */
`timescale 1ns/10ps
module tb_mem_phy_datapath;
    // ========================================
    // stimulus and pins
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    mem_phy_pkg::mem_kind_t mem_kind = mem_phy_pkg::kind_ddr2;
    logic ddr1_burst2 = 1'b0;
    logic multi_sram = 1'b0;
    logic cmd_valid = 1'b0;
    mem_phy_pkg::cmd_t cmd = '0;
    logic slow = 1'b0;
    logic drop_valid = 1'b0;
    logic cmd_ready, rd_valid, mem_select_n, mem_write_n, dq_oe, strobe_oe;
    logic complement_strobe_oe, strobe_in, read_valid_input;
    logic [15:0] addr_rise, addr_fall;
    mem_phy_pkg::pair_t rd_word, dq_out, d_out, dq_in;
    logic [1:0] strobe_out, write_mask_line, memory_input_clock;
    logic [1:0] memory_input_clock_n, write_clock_to_memory;
    logic [1:0] write_clock_to_memory_n, sram_out_clock, sram_out_clock_n;
    int n_errors = 0;
    int check_count = 0;

    always #10 sys_clk = ~sys_clk;

    mem_phy_datapath dut_u (.sys_clk, .rst_b, .mem_kind, .ddr1_burst2,
        .multi_sram, .cmd_valid, .cmd, .cmd_ready, .rd_valid, .rd_word,
        .addr_rise, .addr_fall, .mem_select_n, .mem_write_n, .dq_out, .dq_oe,
        .dq_in, .d_out, .strobe_out, .strobe_oe, .complement_strobe_oe,
        .strobe_in, .read_valid_input, .write_mask_line, .memory_input_clock,
        .memory_input_clock_n, .write_clock_to_memory,
        .write_clock_to_memory_n, .sram_out_clock, .sram_out_clock_n);
    mem_chip_model mem_u (.sys_clk, .rst_b, .mem_select_n, .mem_write_n,
        .addr_rise, .slow, .drop_valid, .dq_in, .strobe_in, .read_valid_input);

    // ========================================
    // shared tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp

    task automatic issue(input logic w, input logic [15:0] a);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = '{write: w, addr: a, wdata: 32'h44332211, wmask: 4'h1};
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: ready never returned", $time);
        end
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        n = 0;
        while (mem_select_n !== 1'b0 && n < 6) begin
            @(negedge sys_clk);
            n++;
        end
        cmp(mem_select_n, 16'h0);
    endtask : issue

    // ========================================
    // scenarios
    task automatic t_write(input mem_phy_pkg::mem_kind_t k, input logic b2);
        logic shared;
        logic one;
        shared = k <= mem_phy_pkg::kind_rl_common_io;
        one = k == mem_phy_pkg::kind_sram_b2 || (k == 0 && b2);
        mem_kind = k;
        ddr1_burst2 = b2;
        multi_sram = k == mem_phy_pkg::kind_sram_b4;
        issue(1'b1, {13'h0a1, k});
        cmp(mem_write_n, 16'h0);
        cmp(k == 4 ? addr_fall : addr_rise, {13'h0a1, k});
        cmp(shared ? dq_out : d_out, 16'h1122);
        cmp(dq_oe, shared);
        cmp(strobe_out, k < 2 ? 2'h2 : 2'h0);
        cmp(strobe_oe, k < 2);
        if (k < 4) cmp(write_mask_line, 2'h1);
        if (k >= 2) cmp(memory_input_clock, 16'h2);
        if (k >= 2) cmp(memory_input_clock_n, 16'h1);
        if (k == 2) cmp(write_clock_to_memory, 16'h2);
        if (k == 2) cmp(write_clock_to_memory_n, 16'h1);
        if (multi_sram) cmp(sram_out_clock, 16'h2);
        if (multi_sram) cmp(sram_out_clock_n, 16'h1);
        @(negedge sys_clk);
        if (one) cmp(shared ? dq_oe : d_out, 16'h0);
        else cmp(shared ? dq_out : d_out, 16'h3344);
        $display("write test done, kind %0d burst2 %0d", k, b2);
    endtask : t_write

    task automatic t_read(input mem_phy_pkg::mem_kind_t k, input logic sl,
                          input logic dv);
        int n;
        mem_kind = k;
        slow = sl;
        drop_valid = dv;
        issue(1'b0, 16'h00a5);
        n = 0;
        while (rd_valid !== 1'b1 && n < 12) begin
            @(negedge sys_clk);
            n++;
        end
        cmp(rd_valid, !dv);
        if (!dv) cmp(rd_word, 16'ha55a);
        repeat (6) @(negedge sys_clk);
        $display("read test done, kind %0d slow %0d drop %0d", k, sl, dv);
    endtask : t_read

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // ========================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        cmp(complement_strobe_oe, 16'h0);
        for (int i = 0; i < 6; i++) begin
            t_write(mem_phy_pkg::mem_kind_t'(3'(i)), 1'b0);
        end
        t_write(mem_phy_pkg::kind_ddr1, 1'b1);
        t_read(mem_phy_pkg::kind_ddr2, 1'b1, 1'b0);
        t_read(mem_phy_pkg::kind_rl_common_io, 1'b0, 1'b0);
        t_read(mem_phy_pkg::kind_rl_common_io, 1'b0, 1'b1);
        complete_run;
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        $display("unexpected at %0t: run timed out", $time);
        complete_run;
    end
endmodule : tb_mem_phy_datapath
